// [rtl/port_cfg_map.svh]
/*
 Register addresses, pages and reset values of the two-port pin configuration block.
 Assumes an 8-bit special-function-register space selected by an 8-bit page number.
*/
`ifndef PORT_CFG_MAP_SVH
`define PORT_CFG_MAP_SVH
// ==========================================
// Addresses
`define ADDR_PORT_B_DATA_LATCH 8'ha0
`define ADDR_PORT_A_OUT_OR_DRIVE 8'ha5
`define ADDR_PORT_B_OUTPUT_TYPE 8'ha6
`define ADDR_PORT_A_CROSSBAR_BYPASS 8'hd5
`define ADDR_PORT_B_CROSSBAR_BYPASS 8'hd6
`define ADDR_PORT_A_ANALOG_SELECT 8'hf2
`define ADDR_PORT_B_ANALOG_SELECT 8'hf3
// ==========================================
// Pages
`define PAGE_CONFIG 8'h00
`define PAGE_DRIVE 8'h0f
// ==========================================
// Reset values and fixed bits
`define RST_ALL_ONES 8'hff
`define RST_ALL_ZEROS 8'h00
`define ANALOG_B_RESERVED_BIT 7
`endif

// [rtl/port_cfg_pkg.sv]
/*
 Shared types of the two-port pin configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package port_cfg_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      sel_none, sel_a_out, sel_a_drv, sel_b_out, sel_a_skip, sel_b_skip, sel_a_ain, sel_b_ain
   } reg_sel_e;
endpackage : port_cfg_pkg

// [rtl/pin_cell_ctrl.sv]
/*
 Per-pin driver and receiver control for one 8-bit port.
 Assumes pads take an output level, an active-low output enable and a pull-up enable.
*/
`timescale 1ns/10ps
module pin_cell_ctrl #(
   parameter int WIDTH = 8
) (
   // Configuration
   input wire logic [WIDTH-1:0] latch,
   input wire logic [WIDTH-1:0] digital_mode,
   input wire logic [WIDTH-1:0] push_pull,
   // Pad controls
   output logic [WIDTH-1:0] pad_out,
   output logic [WIDTH-1:0] pad_oe_n,
   output logic [WIDTH-1:0] pullup_en,
   output logic [WIDTH-1:0] receiver_en
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         // Driver stays live in analog mode; only pull-up and receiver follow the mode
         assign pad_out[i] = latch[i];
         assign pad_oe_n[i] = ~(push_pull[i] | ~latch[i]);
         assign pullup_en[i] = digital_mode[i];
         assign receiver_en[i] = digital_mode[i];
      end
   endgenerate
endmodule : pin_cell_ctrl

// [rtl/sfr_page_decode.sv]
/*
 Decoder from page and address to a register select.
 Assumes the page register lives in the core and is presented steadily.
*/
`timescale 1ns/10ps
`include "port_cfg_map.svh"
module sfr_page_decode (
   // Access
   input wire logic [7:0] page,
   input wire logic [7:0] addr,
   // Select
   output port_cfg_pkg::reg_sel_e sel
);
   import port_cfg_pkg::*;
   always_comb begin
      sel = sel_none;
      if (addr == `ADDR_PORT_A_OUT_OR_DRIVE && page == `PAGE_CONFIG) begin
         sel = sel_a_out;
      end else if (addr == `ADDR_PORT_A_OUT_OR_DRIVE && page == `PAGE_DRIVE) begin
         sel = sel_a_drv;
      end else if (page != `PAGE_CONFIG) begin
         sel = sel_none;
      end else if (addr == `ADDR_PORT_B_OUTPUT_TYPE) begin
         sel = sel_b_out;
      end else if (addr == `ADDR_PORT_A_CROSSBAR_BYPASS) begin
         sel = sel_a_skip;
      end else if (addr == `ADDR_PORT_B_CROSSBAR_BYPASS) begin
         sel = sel_b_skip;
      end else if (addr == `ADDR_PORT_A_ANALOG_SELECT) begin
         sel = sel_a_ain;
      end else if (addr == `ADDR_PORT_B_ANALOG_SELECT) begin
         sel = sel_b_ain;
      end
   end
endmodule : sfr_page_decode

// [rtl/port_pin_config.sv]
/*
 Configuration registers for two 8-bit general-purpose ports, and the data register of port B only.
 Assumes a core that issues single-cycle reads and writes of special function registers,
 with a page number, and single-bit writes on bit-addressable locations.
*/
// How it works
// - Port A bypass bit one skips pin
// - Port B bypass bit one skips pin
// - Port A select zero analog, one digital
// - Analog pin loses pull-up and receiver
// - Port B select bits cover pins six..zero
// - Port B select bit seven reads one
// - Output type zero open-drain, one push-pull
// - Output type acts even in analog mode
// - Port A drive bit one means high
// - Page tells output type from drive strength
// - Data write loads latch low or high
// - Data read returns sampled digital pins
// - Data register on all pages, bit-addressable
`timescale 1ns/10ps
`include "port_cfg_map.svh"
module port_pin_config (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register access
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire port_cfg_pkg::byte_t sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   output port_cfg_pkg::byte_t sfr_rdata,
   // Port A pads
   input wire logic [7:0] port_a_pin_in,
   output logic [7:0] port_a_bypass,
   output logic [7:0] port_a_push_pull,
   output logic [7:0] port_a_high_drive,
   output logic [7:0] port_a_pullup_en,
   output logic [7:0] port_a_receiver_en,
   // Port B pads
   input wire logic [7:0] port_b_pin_in,
   output logic [7:0] port_b_bypass,
   output logic [7:0] port_b_pin_out,
   output logic [7:0] port_b_pin_oe_n,
   output logic [7:0] port_b_pullup_en,
   output logic [7:0] port_b_receiver_en
);
   import port_cfg_pkg::*;

   // ==========================================
   // State
   typedef struct packed {
      byte_t b_latch;
      byte_t a_out;
      byte_t a_drv;
      byte_t b_out;
      byte_t a_skip;
      byte_t b_skip;
      byte_t a_ain;
      byte_t b_ain;
      byte_t rdata;
      byte_t a_pu;
      byte_t b_pu;
      byte_t b_pad;
      byte_t b_oe_n;
   } state_s;

   state_s st;
   state_s next_st;
   reg_sel_e sel;
   byte_t b_pad_c;
   byte_t b_oe_c;
   byte_t b_pu_c;
   byte_t unused_rx_a;
   byte_t unused_rx_b;

   // ==========================================
   // Decode
   sfr_page_decode u_decode (
      .page(sfr_page),
      .addr(sfr_addr),
      .sel(sel)
   );

   function automatic logic is_data(input logic [7:0] a);
      return a == `ADDR_PORT_B_DATA_LATCH;
   endfunction

   // ==========================================
   // Pad control
   pin_cell_ctrl #(.WIDTH(8)) u_cell_b (
      .latch(next_st.b_latch),
      .digital_mode(next_st.b_ain),
      .push_pull(next_st.b_out),
      .pad_out(b_pad_c),
      .pad_oe_n(b_oe_c),
      .pullup_en(b_pu_c),
      .receiver_en(unused_rx_b)
   );
   assign unused_rx_a = next_st.a_ain;

   // ==========================================
   // Next state
   always_comb begin
      next_st = st;
      if (sfr_wr) begin
         // Data register ignores the page
         if (is_data(sfr_addr)) begin
            next_st.b_latch = sfr_wdata;
         end else if (sel == sel_a_out) begin
            next_st.a_out = sfr_wdata;
         end else if (sel == sel_a_drv) begin
            next_st.a_drv = sfr_wdata;
         end else if (sel == sel_b_out) begin
            next_st.b_out = sfr_wdata;
         end else if (sel == sel_a_skip) begin
            next_st.a_skip = sfr_wdata;
         end else if (sel == sel_b_skip) begin
            next_st.b_skip = sfr_wdata;
         end else if (sel == sel_a_ain) begin
            next_st.a_ain = sfr_wdata;
         end else if (sel == sel_b_ain) begin
            // Reserved bit held at one whatever is written
            next_st.b_ain = sfr_wdata | (8'h01 << `ANALOG_B_RESERVED_BIT);
         end
      end else if (sfr_bit_wr && is_data(sfr_addr)) begin
         next_st.b_latch[sfr_bit_sel] = sfr_wdata[0];
      end
      next_st.rdata = st.rdata;
      if (sfr_rd) begin
         // Analog pins read zero since their receiver is off
         if (is_data(sfr_addr)) begin
            next_st.rdata = port_b_pin_in & st.b_ain;
         end else if (sel == sel_a_out) begin
            next_st.rdata = st.a_out;
         end else if (sel == sel_a_drv) begin
            next_st.rdata = st.a_drv;
         end else if (sel == sel_b_out) begin
            next_st.rdata = st.b_out;
         end else if (sel == sel_a_skip) begin
            next_st.rdata = st.a_skip;
         end else if (sel == sel_b_skip) begin
            next_st.rdata = st.b_skip;
         end else if (sel == sel_a_ain) begin
            next_st.rdata = st.a_ain;
         end else if (sel == sel_b_ain) begin
            next_st.rdata = st.b_ain;
         end else begin
            next_st.rdata = `RST_ALL_ZEROS;
         end
      end
      next_st.a_pu = next_st.a_ain;
      next_st.b_pu = b_pu_c;
      next_st.b_pad = b_pad_c;
      next_st.b_oe_n = b_oe_c;
   end

   // ==========================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st.b_latch <= `RST_ALL_ONES;
         st.a_out <= `RST_ALL_ZEROS;
         st.a_drv <= `RST_ALL_ZEROS;
         st.b_out <= `RST_ALL_ZEROS;
         st.a_skip <= `RST_ALL_ZEROS;
         st.b_skip <= `RST_ALL_ZEROS;
         st.a_ain <= `RST_ALL_ONES;
         st.b_ain <= `RST_ALL_ONES;
         st.rdata <= `RST_ALL_ZEROS;
         st.a_pu <= `RST_ALL_ONES;
         st.b_pu <= `RST_ALL_ONES;
         st.b_pad <= `RST_ALL_ONES;
         st.b_oe_n <= `RST_ALL_ONES;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // Outputs
   assign sfr_rdata = st.rdata;
   assign port_a_bypass = st.a_skip;
   assign port_b_bypass = st.b_skip;
   assign port_a_push_pull = st.a_out;
   assign port_a_high_drive = st.a_drv;
   assign port_a_pullup_en = st.a_pu;
   assign port_a_receiver_en = st.a_ain;
   assign port_b_pin_out = st.b_pad;
   assign port_b_pin_oe_n = st.b_oe_n;
   assign port_b_pullup_en = st.b_pu;
   assign port_b_receiver_en = st.b_ain;
endmodule : port_pin_config

// [verification/port_pin_config_sva.sv]
/* Checker for the port configuration block.
 Assumes a bind into port_pin_config and one clock domain. */
`timescale 1ns/10ps
module port_pin_config_sva (
   // Clock and access
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire port_cfg_pkg::byte_t sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire port_cfg_pkg::byte_t sfr_rdata,
   // Pads
   input wire logic [7:0] port_a_bypass,
   input wire logic [7:0] port_a_push_pull,
   input wire logic [7:0] port_a_high_drive,
   input wire logic [7:0] port_a_pullup_en,
   input wire logic [7:0] port_a_receiver_en,
   input wire logic [7:0] port_b_pin_in,
   input wire logic [7:0] port_b_bypass,
   input wire logic [7:0] port_b_pin_out,
   input wire logic [7:0] port_b_pin_oe_n,
   input wire logic [7:0] port_b_receiver_en
);
   logic w0;
   logic [7:0] live;
   assign w0 = sfr_wr && sfr_page == 8'h00;
   // Digital pins only, so analog pins read as zero
   assign live = port_b_pin_in & port_b_receiver_en;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Assertions
   a_a_bypass:
      assert property (w0 && sfr_addr == 8'hd5 |=> port_a_bypass == $past(sfr_wdata))
      else $error("port a bypass");
   a_b_bypass:
      assert property (w0 && sfr_addr == 8'hd6 |=> port_b_bypass == $past(sfr_wdata))
      else $error("port b bypass");
   a_a_out_type:
      assert property (w0 && sfr_addr == 8'ha5 |=> port_a_push_pull == $past(sfr_wdata)
      && $stable(port_a_high_drive))
      else $error("port a output type");
   a_a_drive_page:
      assert property (sfr_wr && sfr_page == 8'h0f && sfr_addr == 8'ha5
      |=> port_a_high_drive == $past(sfr_wdata) && $stable(port_a_push_pull))
      else $error("port a drive");
   a_a_analog_mode:
      assert property (w0 && sfr_addr == 8'hf2 |=> port_a_receiver_en ==
      $past(sfr_wdata) && port_a_pullup_en == port_a_receiver_en)
      else $error("port a analog");
   a_b_analog_mode:
      assert property (w0 && sfr_addr == 8'hf3 |=> port_b_receiver_en[6:0] ==
      $past(sfr_wdata[6:0]))
      else $error("port b analog");
   a_reserved_one:
      assert property (sfr_rd && sfr_page == 8'h00 && sfr_addr == 8'hf3 |=> sfr_rdata[7])
      else $error("reserved bit");
   a_b_latch_load:
      assert property (sfr_wr && sfr_addr == 8'ha0 |=> port_b_pin_out == $past(sfr_wdata))
      else $error("latch load");
   a_bit_load:
      assert property (sfr_bit_wr && !sfr_wr && sfr_addr == 8'ha0
      |=> port_b_pin_out[$past(sfr_bit_sel)] == $past(sfr_wdata[0]))
      else $error("bit load");
   a_b_open_drain:
      assert property (w0 && sfr_addr == 8'ha6
      |=> port_b_pin_oe_n == (~$past(sfr_wdata) & port_b_pin_out))
      else $error("port b driver");
   a_pin_read:
      assert property (sfr_rd && sfr_addr == 8'ha0 |=> sfr_rdata == $past(live))
      else $error("pin read");
   c_bit: cover property (sfr_bit_wr);
   c_read: cover property (sfr_rd && sfr_addr == 8'ha0);
   c_drive: cover property (sfr_wr && sfr_page == 8'h0f);
endmodule : port_pin_config_sva
bind port_pin_config port_pin_config_sva u_port_pin_config_sva (.*);

// [verification/pad_model.sv]
/* Off-chip side of port B pads.
 Assumes pads take a level, an active-low enable and a pull-up enable. */
`timescale 1ns/10ps
module pad_model (
   // From the block
   input wire logic [7:0] port_b_pin_out,
   input wire logic [7:0] port_b_pin_oe_n,
   input wire logic [7:0] port_b_pullup_en,
   // Outside circuit
   input wire logic [7:0] ext_hi,
   output logic [7:0] port_b_pin_in
);
   // Released pins float to the pull-up or to what the outside circuit drives
   assign port_b_pin_in = (~port_b_pin_oe_n & port_b_pin_out) |
      (port_b_pin_oe_n & (port_b_pullup_en | ext_hi));
endmodule : pad_model

// [verification/tb.sv]
/* Self-checking bench of the port configuration block.
 Assumes the pad model and the bound checker. */
`timescale 1ns/10ps
module tb;
   import port_cfg_pkg::*;
   logic core_clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0;
   logic [7:0] sfr_page = 0, sfr_addr = 0, ext_hi = 8'h40;
   logic [2:0] sfr_bit_sel = 0;
   byte_t sfr_wdata = 0, sfr_rdata;
   logic [7:0] port_b_pin_in, port_a_bypass, port_a_push_pull, port_a_high_drive;
   logic [7:0] port_a_pullup_en, port_a_receiver_en, port_b_bypass, port_b_pin_out;
   logic [7:0] port_b_pin_oe_n, port_b_pullup_en, port_b_receiver_en;
   logic [7:0] pg [7] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
   logic [7:0] ad [7] = '{8'hd5, 8'hd6, 8'ha5, 8'ha5, 8'ha6, 8'hf2, 8'hf3};
   logic [7:0] rs [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
   logic [7:0] dt [7] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0, 8'h55, 8'h96, 8'h85};
   int n_mismatch = 0, comparisons = 0;
   port_pin_config u_port_pin_config (.*, .port_a_pin_in(8'h00));
   pad_model u_pad_model (.*);
   initial forever #10 core_clk = ~core_clk;
   // ==========================================
   // Tasks
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfr_page <= p;
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
      @(negedge core_clk);
   endtask : wr
   task rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      sfr_page <= p;
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      @(negedge core_clk);
      chk(sfr_rdata, exp);
   endtask : rd
   task print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   // ==========================================
   // Scenarios
   task t_reset;
      for (int i = 0; i < 7; i++) rd(pg[i], ad[i], rs[i]);
      rd(8'h00, 8'ha0, 8'hff);
      chk(port_b_pin_oe_n, 8'hff);
   endtask : t_reset
   task t_regs;
      // Bit seven of the port b select is written as one
      for (int i = 0; i < 7; i++) wr(pg[i], ad[i], dt[i]);
      for (int i = 0; i < 7; i++) rd(pg[i], ad[i], dt[i]);
      rd(8'h00, 8'ha7, 8'h00);
      rd(8'h0f, 8'hd5, 8'h00);
      chk(port_a_bypass, 8'ha5);
      chk(port_b_bypass, 8'h3c);
      chk(port_a_push_pull, 8'h0f);
      chk(port_a_high_drive, 8'hf0);
      chk(port_a_pullup_en, 8'h96);
      chk(port_a_receiver_en, 8'h96);
      chk(port_b_receiver_en, 8'h85);
      chk(port_b_pullup_en, 8'h85);
   endtask : t_regs
   task t_data;
      wr(8'h0f, 8'ha0, 8'h0f);
      chk(port_b_pin_out, 8'h0f);
      chk(port_b_pin_oe_n, 8'h0a);
      @(posedge core_clk);
      sfr_addr <= 8'ha0;
      sfr_wdata <= 8'h00;
      sfr_bit_sel <= 3'h3;
      sfr_bit_wr <= 1'b1;
      @(posedge core_clk);
      sfr_bit_wr <= 1'b0;
      @(negedge core_clk);
      chk(port_b_pin_out, 8'h07);
      rd(8'h00, 8'ha0, 8'h05);
   endtask : t_data
   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset;
      t_regs;
      t_data;
      print_verdict;
   end
   // Whole run needs about 66 cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      n_mismatch++;
      print_verdict;
   end
endmodule : tb
